// ---- rtl/mise_consts.svh ----
// Function
// [RULE_01] OR-immediate ORs 8-bit operand into accumulator, sets only zero flag, one cycle.
// [RULE_02] Page-read copies secondary page register 0..15 into accumulator, one cycle, no flags.
// [RULE_03] Page-write stores accumulator into page register 0..15, one cycle, no flags.
// [RULE_04] Long-call pushes program counter plus one and advances stack pointer.
// [RULE_05] Long-call then loads 10-bit target into program counter; two cycles, no flags.
// [RULE_06] Long-jump loads 10-bit target, leaves stack alone; two cycles, no flags.
// [RULE_07] Load-immediate writes 8-bit value into accumulator, one cycle, flags unchanged.
// [RULE_08] Zero flag is one when OR result is zero, otherwise cleared.
`ifndef MISE_CONSTS_SVH
`define MISE_CONSTS_SVH
`define MISE_ACC_RST 8'h00
`define MISE_PC_RST 10'h000
`define MISE_SP_RST 3'h0
`define MISE_PAGE_RST 8'h00
`define MISE_SHORT_CYC 2'h1
`define MISE_LONG_CYC 2'h2
`endif

// ---- rtl/mise_pkg.sv ----
package mise_pkg;
    typedef enum logic [2:0] {
        MISE_NOP, MISE_OR_IMM, MISE_PG_RD, MISE_PG_WR, MISE_LONG_CALL_OP_OP, MISE_LJUMP_OP, MISE_LD_IMM
    } mise_op_e;
    typedef struct packed {
        logic valid;
        mise_op_e op;
        logic [9:0] operand;
    } mise_instr_s;
    typedef struct packed {
        logic valid;
        logic [9:0] addr;
    } mise_push_s;
endpackage

// ---- rtl/mise_page_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
// Sixteen-entry secondary page register file; one write port, one read port.
module mise_page_regs #(
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
`include "mise_consts.svh"
    logic [7:0] mem_q [DEPTH];
    // The operand carries a 4-bit index, so any other depth cannot be addressed.
    if (DEPTH != 16) begin : g_depth_check
        $error("mise_page_regs: DEPTH must be 16");
    end
    // Storage resets so that reads after reset return a defined value.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= `MISE_PAGE_RST;
        end else if (wr_en) begin
            mem_q[addr] <= wr_data; // RULE_03
        end
    end
    // Read is combinational so the accumulator loads in the same cycle.
    assign rd_data = mem_q[addr];
endmodule // mise_page_regs
`default_nettype wire

// ---- rtl/mise_exec.sv ----
`timescale 1ns/1ns
`default_nettype none
// Executes the six-instruction subset against accumulator, zero flag, stack and page regs.
module mise_exec #(
    parameter int STACK_DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire mise_pkg::mise_instr_s instr,
    output logic instr_ready,
    output logic [7:0] accumulator,
    output logic zero_flag,
    output logic [9:0] program_counter,
    output logic [2:0] stack_ptr,
    output mise_pkg::mise_push_s push
);
    import mise_pkg::*;
`include "mise_consts.svh"
    typedef struct packed {
        logic [7:0] acc;
        logic z;
        logic [9:0] pc;
        logic [2:0] sp;
        logic busy;
        logic [9:0] target;
        mise_push_s push;
    } mise_state_s;
    mise_state_s st_q, st_d;
    logic [7:0] page_rd;
    logic page_we;
    // The stack pointer is three bits wide, so deeper stacks cannot be tracked.
    if (STACK_DEPTH < 1 || STACK_DEPTH > 7) begin : g_depth_check
        $error("mise_exec: STACK_DEPTH out of range");
    end
    mise_page_regs #(.DEPTH(16)) u_page (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .wr_en(page_we),
        .addr(instr.operand[3:0]),
        .wr_data(st_q.acc),
        .rd_data(page_rd)
    );
    // Two-cycle branches hold off the next instruction during their second cycle.
    assign instr_ready = !st_q.busy;
    assign page_we = instr.valid && instr_ready && instr.op == MISE_PG_WR; // RULE_03
    // Next-state logic; flags change only on OR-immediate.
    always_comb begin
        logic [7:0] orv;
        orv = st_q.acc | instr.operand[7:0];
        st_d = st_q;
        st_d.push.valid = 1'b0;
        if (st_q.busy) begin
            st_d.busy = 1'b0;
            st_d.pc = st_q.target; // RULE_05 RULE_06
        end else if (instr.valid) begin
            st_d.pc = st_q.pc + 10'h001;
            case (instr.op)
                MISE_OR_IMM: begin
                    st_d.acc = orv; // RULE_01
                    st_d.z = (orv == 8'h00); // RULE_08
                end
                MISE_LD_IMM: st_d.acc = instr.operand[7:0]; // RULE_07
                MISE_PG_RD: st_d.acc = page_rd; // RULE_02
                MISE_LONG_CALL_OP_OP: begin
                    st_d.push.valid = 1'b1; // RULE_04
                    st_d.push.addr = st_q.pc + 10'h001;
                    st_d.sp = st_q.sp + 3'h1;
                    st_d.busy = 1'b1;
                    st_d.target = instr.operand;
                end
                MISE_LJUMP_OP: begin
                    st_d.busy = 1'b1; // RULE_06
                    st_d.target = instr.operand;
                end
                default: ;
            endcase
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '{acc: `MISE_ACC_RST, z: 1'b0, pc: `MISE_PC_RST, sp: `MISE_SP_RST,
                      busy: 1'b0, target: 10'h000, push: '0};
        end else begin
            st_q <= st_d;
        end
    end
    assign accumulator = st_q.acc;
    assign zero_flag = st_q.z;
    assign program_counter = st_q.pc;
    assign stack_ptr = st_q.sp;
    assign push = st_q.push;

    logic take;
    assign take = instr.valid && instr_ready;
    sequence call_take_s;
        take && instr.op == MISE_LONG_CALL_OP_OP;
    endsequence
    sequence jump_take_s;
        take && instr.op == MISE_LJUMP_OP;
    endsequence
    or_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_01
        take && instr.op == MISE_OR_IMM |=> accumulator == ($past(accumulator) | $past(instr.operand[7:0])))
        else $error("OR result wrong");
    zero_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_08
        take && instr.op == MISE_OR_IMM |=> zero_flag == (accumulator == 8'h00))
        else $error("zero flag wrong");
    flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
        !(take && instr.op == MISE_OR_IMM) |=> $stable(zero_flag))
        else $error("zero flag changed");
    load_imm_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
        take && instr.op == MISE_LD_IMM |=> accumulator == $past(instr.operand[7:0]))
        else $error("load immediate wrong");
    page_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_02
        take && instr.op == MISE_PG_RD |=> accumulator == $past(page_rd))
        else $error("page read wrong");
    page_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_03
        take && instr.op == MISE_PG_WR |=> $stable(accumulator) && $stable(zero_flag))
        else $error("page write disturbed state");
    call_push_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
        call_take_s |=> push.valid && push.addr == $past(program_counter) + 10'h001
        && stack_ptr == $past(stack_ptr) + 3'h1)
        else $error("call push wrong");
    call_target_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
        call_take_s |=> !instr_ready ##1 program_counter == $past(instr.operand, 2) && instr_ready)
        else $error("call target wrong");
    jump_target_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
        jump_take_s |=> (!push.valid && $stable(stack_ptr)) ##1
        program_counter == $past(instr.operand, 2))
        else $error("jump target wrong");

    // Steps of a page write followed by a read of the same entry.
    sequence wr_take_s;
        take && instr.op == MISE_PG_WR;
    endsequence
    sequence rd_same_s;
        take && instr.op == MISE_PG_RD && instr.operand[3:0] == $past(instr.operand[3:0]);
    endsequence
    // A read right after a write must see the written accumulator value.
    page_land_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_03
        wr_take_s ##1 rd_same_s |=> accumulator == $past(accumulator, 2))
        else $error("page write did not land");
    // The return-address pulse lasts exactly one cycle.
    push_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
        push.valid |=> !push.valid)
        else $error("push pulse too long");
    // Only a call moves the stack pointer.
    sp_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
        !(take && instr.op == MISE_LONG_CALL_OP_OP) |=> $stable(stack_ptr))
        else $error("stack pointer moved");
    // Single-cycle operations step the program counter by one.
    pc_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_01
        take && instr.op != MISE_LONG_CALL_OP_OP && instr.op != MISE_LJUMP_OP
        |=> program_counter == $past(program_counter) + 10'h001 && instr_ready)
        else $error("program counter step wrong");
    // Both branches hold off exactly one following cycle.
    branch_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
        take && (instr.op == MISE_LONG_CALL_OP_OP || instr.op == MISE_LJUMP_OP)
        |=> !instr_ready ##1 instr_ready)
        else $error("branch occupancy wrong");
    // Load-immediate must not touch the zero flag.
    load_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
        take && instr.op == MISE_LD_IMM |=> $stable(zero_flag) && !push.valid)
        else $error("load immediate touched flag");
    // Page read must not touch the zero flag.
    read_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_02
        take && instr.op == MISE_PG_RD |=> $stable(zero_flag) && !push.valid)
        else $error("page read touched flag");
    // A jump leaves accumulator and flag alone.
    jump_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
        jump_take_s |=> $stable(accumulator) && $stable(zero_flag))
        else $error("jump disturbed state");
    // A call leaves the flag alone through both of its cycles.
    call_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
        call_take_s |=> $stable(zero_flag) ##1 $stable(zero_flag))
        else $error("call touched flag");
    // Nothing executes in the held-off cycle.
    busy_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_05
        !instr_ready |=> $stable(accumulator) && $stable(zero_flag) && !push.valid)
        else $error("held-off cycle changed state");
    // Without a taken instruction or a pending branch the state stands.
    idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_01
        !take && instr_ready |=> $stable(program_counter) && $stable(accumulator))
        else $error("idle cycle changed state");
    // First cycle of a call or jump still steps past the branch word.
    branch_step_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
        take && (instr.op == MISE_LONG_CALL_OP_OP || instr.op == MISE_LJUMP_OP)
        |=> program_counter == $past(program_counter) + 10'h001)
        else $error("branch first step wrong");
    // An all-zero OR result raises the flag.
    or_zero_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_08
        take && instr.op == MISE_OR_IMM && (accumulator | instr.operand[7:0]) == 8'h00
        |=> zero_flag)
        else $error("zero flag not set");
    // A non-zero OR result clears the flag.
    or_zero_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_08
        take && instr.op == MISE_OR_IMM && (accumulator | instr.operand[7:0]) != 8'h00
        |=> !zero_flag)
        else $error("zero flag not cleared");
    // A page write leaves the stack untouched.
    write_stack_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_03
        wr_take_s |=> !push.valid && $stable(stack_ptr))
        else $error("page write touched stack");
    // A no-operation only steps the program counter.
    nop_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_01
        take && instr.op == MISE_NOP |=> $stable(accumulator) && $stable(zero_flag))
        else $error("no-operation changed state");
endmodule // mise_exec
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import mise_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    mise_instr_s instr = '0;
    logic instr_ready;
    logic [7:0] accumulator;
    logic zero_flag;
    logic [9:0] program_counter;
    logic [2:0] stack_ptr;
    mise_push_s push;
    int fail_count = 0;
    int tests_run = 0;
    int m_acc, m_z, m_pc, m_sp;
    int m_page [16];
    logic [31:0] seed = 32'hf6888e3b;
    mise_op_e rop;

    mise_exec #(.STACK_DEPTH(4)) i_mise_exec (.ref_clk(ref_clk), .rst_n(rst_n), .instr(instr),
        .instr_ready(instr_ready), .accumulator(accumulator), .zero_flag(zero_flag),
        .program_counter(program_counter), .stack_ptr(stack_ptr), .push(push));

    // Free-running 10 MHz clock.
    initial forever #50 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Case inequality lets an unknown output count as a mismatch.
    task automatic check(input string what, input int exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp[31:0]) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic check_state(input int push_exp);
        check("accumulator", m_acc, accumulator);
        check("zero_flag", m_z, zero_flag);
        check("program_counter", m_pc, program_counter);
        check("stack_ptr", m_sp, stack_ptr);
        check("push_valid", push_exp, push.valid);
        if (push_exp != 0) check("push_addr", m_pc, push.addr);
    endtask

    // One instruction; the model steps beside it and every result is compared.
    task automatic issue(input mise_op_e op, input logic [9:0] opd);
        int long_op;
        long_op = (op == MISE_LONG_CALL_OP_OP || op == MISE_LJUMP_OP);
        instr <= '{1'b1, op, opd};
        @(posedge ref_clk);
        instr.valid <= 1'b0;
        m_pc = (m_pc + 1) % 1024;
        case (op)
            MISE_OR_IMM: begin
                m_acc = m_acc | opd[7:0];
                m_z = (m_acc == 0);
            end
            MISE_LD_IMM: m_acc = opd[7:0];
            MISE_PG_RD: m_acc = m_page[opd[3:0]];
            MISE_PG_WR: m_page[opd[3:0]] = m_acc;
            MISE_LONG_CALL_OP_OP: m_sp = m_sp + 1;
            default: ;
        endcase
        @(negedge ref_clk);
        check_state(op == MISE_LONG_CALL_OP_OP);
        check("instr_ready", !long_op, instr_ready);
        if (long_op != 0) begin
            @(posedge ref_clk);
            m_pc = opd;
            @(negedge ref_clk);
            check_state(0);
        end
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Watchdog: the run needs well under a thousand cycles.
    initial begin
        #(5000 * 100);
        fail_count++;
        wrap_up();
    end

    // Directed corner cases first, then random traffic; calls stay within stack depth.
    initial begin
        m_acc = 0;
        m_z = 0;
        m_pc = 0;
        m_sp = 0;
        foreach (m_page[i]) m_page[i] = 0;
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(negedge ref_clk);
        check_state(0);
        issue(MISE_LD_IMM, 10'h000);
        issue(MISE_OR_IMM, 10'h000);
        issue(MISE_LD_IMM, 10'h0aa);
        issue(MISE_OR_IMM, 10'h350);
        issue(MISE_PG_WR, 10'h00f);
        issue(MISE_PG_RD, 10'h000);
        issue(MISE_PG_RD, 10'h00f);
        issue(MISE_LONG_CALL_OP_OP, 10'h3ff);
        issue(MISE_LJUMP_OP, 10'h000);
        for (int n = 0; n < 300; n++) begin
            seed = xs(seed);
            rop = mise_op_e'(seed % 7);
            if (rop == MISE_LONG_CALL_OP_OP && m_sp >= 3) rop = MISE_LJUMP_OP;
            issue(rop, seed[25:16]);
        end
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
